/* hw/psc_pkg.sv */
//
// Purpose: Shared constants for the parameter store and reset command block.
// Assumes: 40 MHz clock, classic Wishbone register access with 32-bit data.
// Notes:   Register offsets are word indices; byte address is four times the index.
package psc_pkg;

    // ******************************************************
    // Register map (word indices)
    // ******************************************************
    localparam logic [9:0] IDX_RETRY  = 10'h05F;
    localparam logic [9:0] IDX_CMD    = 10'h060;
    localparam logic [9:0] IDX_STATUS = 10'h061;

    localparam logic [15:0] RETRY_RESET = 16'h0000;

    // Status register bit positions.
    localparam int ST_BUSY    = 0;
    localparam int ST_MIDRUN  = 1;
    localparam int ST_RETRY   = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_MOTION  = 4;

    // ******************************************************
    // Command codes and read-back values
    // ******************************************************
    localparam logic [15:0] CMD_RESET     = 16'hFFFA;
    localparam logic [15:0] CMD_DEF_MID   = 16'hFFFB;
    localparam logic [15:0] CMD_USER_MID  = 16'hFFFC;
    localparam logic [15:0] CMD_FACTORY   = 16'hFFFD;
    localparam logic [15:0] CMD_USER      = 16'hFFFE;
    localparam logic [15:0] CMD_DEFAULTS  = 16'hFFFF;
    localparam logic [15:0] CMD_SAVE      = 16'h0001;

    localparam logic [1:0] RB_OK      = 2'h0;
    localparam logic [1:0] RB_BUSY    = 2'h1;
    localparam logic [1:0] RB_FAILED  = 2'h2;

    localparam logic [15:0] CTRL_RUN = 16'h0014;

    // ******************************************************
    // Timing
    // ******************************************************
    localparam longint CLK_HZ          = 40_000_000;
    localparam longint SAVE_TIMEOUT_MS = 200;
    localparam longint SAVE_CYCLES     = CLK_HZ / 1000 * SAVE_TIMEOUT_MS;
    localparam longint SECOND_CYCLES   = CLK_HZ;

    typedef enum logic [2:0] {
        PSC_IDLE,
        PSC_LOAD,
        PSC_SAVE,
        PSC_MID,
        PSC_RESET
    } psc_state_t;

endpackage : psc_pkg

/* hw/psc_retry_timer.sv */
//
// Purpose: Delays the repetition of a failed safe-position run.
// Assumes: Fail is a one-cycle pulse from the drive.
// Notes:   Interval is re-read every cycle, so writing zero cancels a pending retry.
//
`timescale 1ns/100ps
module psc_retry_timer #(
    parameter longint SEC_CYC = 40_000_000
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstSync_n,
    // Control
    input  wire logic [15:0] interval,
    input  wire logic        failPulse,
    // Result
    output logic             firePulse,
    output logic             pending
);
    localparam int TW = $clog2(SEC_CYC);
    localparam logic [TW-1:0] TICK_LAST = TW'(SEC_CYC - 1);

    logic [TW-1:0] tick;
    logic [15:0]   secDone;

    if (SEC_CYC < 2) begin : g_badSec
        $error("SEC_CYC must be at least 2");
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pending   <= 1'b0;
            firePulse <= 1'b0;
            tick      <= '0;
            secDone   <= 16'h0000;
        end else begin
            firePulse <= 1'b0;
            if (failPulse && interval != 16'h0000) begin
                pending <= 1'b1;
                tick    <= '0;
                secDone <= 16'h0000;
            end else if (pending && interval == 16'h0000) begin
                pending <= 1'b0;
            end else if (pending) begin
                if (tick == TICK_LAST) begin
                    tick    <= '0;
                    secDone <= 16'(secDone + 16'h0001);
                    if (16'(secDone + 16'h0001) >= interval) begin
                        pending   <= 1'b0;
                        firePulse <= 1'b1;
                    end
                end else begin
                    tick <= TW'(tick + 1'b1);
                end
            end
        end
    end
endmodule : psc_retry_timer

/* hw/psc_top.sv */
//
// Purpose: Command interpreter for the store, restore and reset command word.
// Assumes: Drive and non-volatile store answer with pulses.
// Notes:   Mid-range run supervision and safe-run retry live here as well.
//
`timescale 1ns/100ps
module psc_top #(
    parameter int     ADR_W    = 12,
    parameter longint SAVE_CYC = psc_pkg::SAVE_CYCLES,
    parameter longint SEC_CYC  = psc_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    // Drive status
    input  wire logic             driveStandstill,
    input  wire logic             safeTrigger,
    input  wire logic             safeRunFailed,
    input  wire logic             midRunDone,
    input  wire logic [15:0]      ctrlWord,
    input  wire logic [31:0]      targetPos,
    // Non-volatile memory status
    input  wire logic             nvmValid,
    input  wire logic             nvmDone,
    input  wire logic             nvmError,
    // Commands to the device
    output logic                  deviceReset,
    output logic                  paramLoadDefaults,
    output logic                  paramLoadUser,
    output logic                  identityClear,
    output logic                  nvmStore,
    output logic                  midRunStart,
    output logic                  midRunToPosRange,
    output logic                  midRunAbort,
    output logic                  safeRunStart,
    output logic                  motionAllow
);
    import psc_pkg::*;

    localparam int SW = $clog2(SAVE_CYC + 1);
    localparam logic [SW-1:0] SAVE_LAST = SW'(SAVE_CYC - 1);

    if (ADR_W < 12) begin : g_badAdr
        $error("ADR_W too small for the register map");
    end
    if (SAVE_CYC < 1) begin : g_badSave
        $error("SAVE_CYC must be at least 1");
    end

    // ******************************************************
    // Functions
    // ******************************************************
    function automatic logic [9:0] idxOf(input logic [ADR_W-1:0] adr);
        idxOf = adr[11:2];
    endfunction : idxOf

    function automatic logic isCommand(input logic [15:0] v);
        isCommand = (v == CMD_RESET) || (v == CMD_DEF_MID) ||
                    (v == CMD_USER_MID) || (v == CMD_FACTORY) ||
                    (v == CMD_USER) || (v == CMD_DEFAULTS) ||
                    (v == CMD_SAVE);
    endfunction : isCommand

    // ******************************************************
    // Reset synchroniser
    // ******************************************************
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // ******************************************************
    // Register bus
    // ******************************************************
    logic [31:0]     rdValue;
    logic            wrPulse;
    logic [9:0]      wrIdx;
    logic [1:0]      wrSel;
    logic [15:0]     wrData;
    logic [15:0]     retryInterval;
    logic [1:0]      cmdStatus;
    logic            refused;
    logic            midRunActive;
    logic            retryPending;
    logic            retryFire;
    psc_state_t      state;

    psc_wb_slave u_bus (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_ack_o  (wb_ack_o),
        .wb_dat_o  (wb_dat_o),
        .rdValue   (rdValue),
        .wrPulse   (wrPulse)
    );

    // Address, lanes and data are captured so the write lands with ack.
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wrIdx  <= 10'h000;
            wrSel  <= 2'h0;
            wrData <= 16'h0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wrIdx  <= idxOf(wb_adr_i);
            wrSel  <= wb_sel_i[1:0];
            wrData <= wb_dat_i[15:0];
        end
    end

    // Unmapped words read as zero and ignore writes.
    always_comb begin
        rdValue = 32'h0000_0000;
        case (idxOf(wb_adr_i))
            IDX_RETRY: begin
                rdValue[15:0] = retryInterval;
            end
            IDX_CMD: begin
                rdValue[1:0] = cmdStatus;
            end
            IDX_STATUS: begin
                rdValue[ST_BUSY]    = (state != PSC_IDLE);
                rdValue[ST_MIDRUN]  = midRunActive;
                rdValue[ST_RETRY]   = retryPending;
                rdValue[ST_REFUSED] = refused;
                rdValue[ST_MOTION]  = motionAllow;
            end
            default: begin
                rdValue = 32'h0000_0000;
            end
        endcase
    end

    // ******************************************************
    // Retry interval register
    // ******************************************************
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            retryInterval <= RETRY_RESET;
        end else if (wrPulse && wrIdx == IDX_RETRY) begin
            if (wrSel[0]) begin
                retryInterval[7:0] <= wrData[7:0];
            end
            if (wrSel[1]) begin
                retryInterval[15:8] <= wrData[15:8];
            end
        end
    end

    psc_retry_timer #(
        .SEC_CYC (SEC_CYC)
    ) u_retry (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .interval  (retryInterval),
        .failPulse (safeRunFailed),
        .firePulse (retryFire),
        .pending   (retryPending)
    );

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            safeRunStart <= 1'b0;
        end else begin
            safeRunStart <= safeTrigger || retryFire;
        end
    end

    // ******************************************************
    // Command acceptance
    // ******************************************************
    logic cmdWrite;
    logic cmdAccept;

    assign cmdWrite = wrPulse && (wrIdx == IDX_CMD);
    assign cmdAccept = cmdWrite && (wrSel == 2'h3) && isCommand(wrData) &&
                       driveStandstill && (state == PSC_IDLE) && !midRunActive;

    // Refused writes leave no trace except this sticky flag; set beats clear.
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            refused <= 1'b0;
        end else if (cmdWrite && !cmdAccept) begin
            refused <= 1'b1;
        end else if (wrPulse && wrIdx == IDX_STATUS && wrSel[0] && wrData[ST_REFUSED]) begin
            refused <= 1'b0;
        end
    end

    // ******************************************************
    // Command sequencer
    // ******************************************************
    logic          needSave;
    logic          needMid;
    logic [SW-1:0] saveCnt;
    logic          saveEnd;
    logic          saveFail;

    assign saveFail = nvmError || (saveCnt == SAVE_LAST && !nvmDone);
    assign saveEnd  = nvmDone || saveFail;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state             <= PSC_IDLE;
            needSave          <= 1'b0;
            needMid           <= 1'b0;
            saveCnt           <= '0;
            deviceReset       <= 1'b0;
            paramLoadDefaults <= 1'b0;
            paramLoadUser     <= 1'b0;
            identityClear     <= 1'b0;
            nvmStore          <= 1'b0;
            midRunStart       <= 1'b0;
            midRunToPosRange  <= 1'b0;
        end else begin
            paramLoadDefaults <= 1'b0;
            paramLoadUser     <= 1'b0;
            identityClear     <= 1'b0;
            nvmStore          <= 1'b0;
            midRunStart       <= 1'b0;
            case (state)
                PSC_IDLE: begin
                    if (cmdAccept) begin
                        case (wrData)
                            CMD_RESET: begin
                                deviceReset <= 1'b1;
                                state       <= PSC_RESET;
                            end
                            CMD_DEF_MID: begin
                                paramLoadDefaults <= 1'b1;
                                needSave          <= 1'b1;
                                needMid           <= 1'b1;
                                midRunToPosRange  <= 1'b0;
                                state             <= PSC_LOAD;
                            end
                            CMD_USER_MID: begin
                                paramLoadUser    <= 1'b1;
                                needSave         <= 1'b0;
                                needMid          <= 1'b1;
                                midRunToPosRange <= 1'b1;
                                state            <= PSC_LOAD;
                            end
                            CMD_FACTORY: begin
                                paramLoadDefaults <= 1'b1;
                                identityClear     <= 1'b1;
                                needSave          <= 1'b1;
                                needMid           <= 1'b0;
                                state             <= PSC_LOAD;
                            end
                            CMD_USER: begin
                                paramLoadUser <= 1'b1;
                                needSave      <= 1'b0;
                                needMid       <= 1'b0;
                                state         <= PSC_LOAD;
                            end
                            CMD_DEFAULTS: begin
                                paramLoadDefaults <= 1'b1;
                                needSave          <= 1'b0;
                                needMid           <= 1'b0;
                                state             <= PSC_LOAD;
                            end
                            default: begin
                                nvmStore <= 1'b1;
                                needSave <= 1'b0;
                                needMid  <= 1'b0;
                                saveCnt  <= '0;
                                state    <= PSC_SAVE;
                            end
                        endcase
                    end
                end
                PSC_LOAD: begin
                    if (needSave) begin
                        nvmStore <= 1'b1;
                        saveCnt  <= '0;
                        state    <= PSC_SAVE;
                    end else if (needMid) begin
                        state <= PSC_MID;
                    end else begin
                        state <= PSC_IDLE;
                    end
                end
                PSC_SAVE: begin
                    saveCnt <= SW'(saveCnt + 1'b1);
                    if (saveEnd) begin
                        state <= needMid ? PSC_MID : PSC_IDLE;
                    end
                end
                PSC_MID: begin
                    midRunStart <= 1'b1;
                    needMid     <= 1'b0;
                    state       <= PSC_IDLE;
                end
                // The device is being reset; stay here until rst_n falls.
                PSC_RESET: begin
                    deviceReset <= 1'b1;
                end
                default: begin
                    state <= PSC_IDLE;
                end
            endcase
        end
    end

    // ******************************************************
    // Command read-back status
    // ******************************************************
    logic bootDone;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bootDone  <= 1'b0;
            cmdStatus <= RB_OK;
        end else begin
            bootDone <= 1'b1;
            if (!bootDone) begin
                cmdStatus <= nvmValid ? RB_OK : RB_FAILED;
            end else if (nvmStore) begin
                cmdStatus <= RB_BUSY;
            end else if (state == PSC_SAVE && saveEnd) begin
                cmdStatus <= saveFail ? RB_FAILED : RB_OK;
            end
        end
    end

    // ******************************************************
    // Mid-range run supervision
    // ******************************************************
    logic [15:0] ctrlAtStart;
    logic [15:0] ctrlPrev;
    logic [31:0] targetAtStart;
    logic        staleTarget;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            midRunActive  <= 1'b0;
            midRunAbort   <= 1'b0;
            ctrlAtStart   <= 16'h0000;
            ctrlPrev      <= 16'h0000;
            targetAtStart <= 32'h0000_0000;
            staleTarget   <= 1'b0;
        end else begin
            midRunAbort <= 1'b0;
            ctrlPrev    <= ctrlWord;
            if (midRunStart) begin
                midRunActive  <= 1'b1;
                ctrlAtStart   <= ctrlWord;
                targetAtStart <= targetPos;
                staleTarget   <= 1'b1;
            end else if (midRunActive) begin
                if (ctrlWord != ctrlAtStart) begin
                    midRunAbort  <= 1'b1;
                    midRunActive <= 1'b0;
                end else if (midRunDone) begin
                    midRunActive <= 1'b0;
                end
            end else if (targetPos != targetAtStart || ctrlWord != ctrlPrev) begin
                staleTarget <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            motionAllow <= 1'b1;
        end else begin
            motionAllow <= !midRunActive && !midRunStart &&
                           !(staleTarget && ctrlWord == CTRL_RUN);
        end
    end

endmodule : psc_top

/* hw/psc_wb_slave.sv */
//
// Purpose: Classic Wishbone slave front end with registered acknowledge.
// Assumes: Master holds the request until it samples ack.
// Notes:   Write strobe and read data are produced at the edge that raises ack.
//
`timescale 1ns/100ps
module psc_wb_slave (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstSync_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Register side
    input  wire logic [31:0] rdValue,
    output logic             wrPulse
);
    logic req;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Ack falls the cycle after it rose, so back-to-back requests are spaced.
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wb_ack_o <= 1'b0;
            wrPulse  <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wrPulse  <= req && wb_we_i;
            if (req) begin
                wb_dat_o <= rdValue;
            end
        end
    end
endmodule : psc_wb_slave

/* tb/psc_checker.sv */
// Purpose: Port assertions for psc_top.
// Assumes: Classic Wishbone master; one clock.
// Notes:   Bound to every psc_top.
`timescale 1ns/100ps
module psc_checker
    import psc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        safeTrigger,
    input wire logic        deviceReset,
    input wire logic        paramLoadDefaults,
    input wire logic        paramLoadUser,
    input wire logic        identityClear,
    input wire logic        nvmStore,
    input wire logic        safeRunStart
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not a single pulse one cycle after request.");
    chk_reset_cause: assert property ($rose(deviceReset) |-> $past(wb_ack_o && wb_we_i && wb_dat_i[15:0] == CMD_RESET))
        else $error("Device reset without its command.");
    chk_reset_hold: assert property (deviceReset |=> deviceReset)
        else $error("Device reset dropped.");
    chk_defaults_cause: assert property ($rose(paramLoadDefaults) |-> $past(wb_ack_o && wb_we_i))
        else $error("Defaults loaded without a write.");
    chk_user_cause: assert property ($rose(paramLoadUser) |-> $past(wb_ack_o && wb_we_i && (wb_dat_i[15:0] == CMD_USER || wb_dat_i[15:0] == CMD_USER_MID)))
        else $error("User set loaded without its command.");
    chk_ident_pair: assert property (identityClear |-> paramLoadDefaults ##1 nvmStore)
        else $error("Identity clear not with defaults and store.");
    chk_store_pulse: assert property (nvmStore |=> !nvmStore)
        else $error("Store request longer than one cycle.");
    chk_safe_start: assert property (safeTrigger |=> safeRunStart)
        else $error("Safe run did not start after trigger.");
endmodule : psc_checker
bind psc_top psc_checker psc_checker_inst (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_i,
    .wb_ack_o, .safeTrigger, .deviceReset, .paramLoadDefaults, .paramLoadUser, .identityClear, .nvmStore, .safeRunStart);

/* tb/psc_drive_model.sv */
// Purpose: Drive and memory stand-in answering store and mid-range runs.
// Assumes: Requests are one-cycle pulses.
// Notes:   failMode turns every save into a failure.
`timescale 1ns/100ps
module psc_drive_model (
    input  wire logic clk,
    input  wire logic nvmStore,
    input  wire logic midRunStart,
    input  wire logic failMode,
    output logic      nvmDone = 1'b0,
    output logic      nvmError = 1'b0,
    output logic      midRunDone = 1'b0
);
    int sc = 0;
    int mc = 0;
    // save ends well inside the allowed time.
    always @(posedge clk) begin
        sc <= nvmStore ? 8 : (sc > 0 ? sc - 1 : 0);
        mc <= midRunStart ? 12 : (mc > 0 ? mc - 1 : 0);
        nvmDone <= sc == 1 && !failMode;
        nvmError <= sc == 1 && failMode;
        midRunDone <= mc == 1;
    end
endmodule : psc_drive_model

/* tb/tb.sv */
// Purpose: Self-checking bench for psc_top.
// Assumes: Short save and second counts.
// Notes:   Pulses are counted on the falling edge.
`timescale 1ns/100ps
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin badCount++; $display("Error %0t got %h exp %h", $time, a, e); end end
module tb;
    import psc_pkg::*;
    logic clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, failMode = 0;
    logic driveStandstill = 1, safeTrigger = 0, safeRunFailed = 0, nvmValid = 1;
    logic [11:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, targetPos = '0, wb_dat_o, rd;
    logic [15:0] ctrlWord = 16'h0014;
    logic wb_ack_o, midRunDone, nvmDone, nvmError, deviceReset, paramLoadDefaults, paramLoadUser;
    logic identityClear, nvmStore, midRunStart, midRunAbort, safeRunStart, motionAllow;
    logic midRunToPosRange;
    logic [6:0] g;
    int badCount = 0, testsRun = 0, b[7], pc[7] = '{default: 0};
    always #12.5 clk = ~clk;
    psc_top #(.SAVE_CYC(50), .SEC_CYC(10)) psc_top_inst (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .driveStandstill,
        .safeTrigger, .safeRunFailed, .midRunDone, .ctrlWord, .targetPos, .nvmValid, .nvmDone,
        .nvmError, .deviceReset, .paramLoadDefaults, .paramLoadUser, .identityClear, .nvmStore,
        .midRunStart, .midRunToPosRange, .midRunAbort, .safeRunStart, .motionAllow);
    psc_drive_model psc_drive_model_inst (.clk, .nvmStore, .midRunStart, .failMode, .nvmDone,
        .nvmError, .midRunDone);
    always @(negedge clk) for (int i = 0; i < 7; i++) pc[i] += {paramLoadDefaults, paramLoadUser,
        identityClear, nvmStore, midRunStart, midRunAbort, safeRunStart} >> i & 1;
    task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge clk); wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= {16'h0000, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o; wb_cyc_i <= 0; wb_stb_i <= 0;
    endtask : wb
    // Issues a command, waits, then records which pulses appeared.
    task automatic cmd(input logic [15:0] c, input int wt);
        b = pc; wb(1, {IDX_CMD, 2'b00}, c); repeat (wt) @(posedge clk);
        for (int i = 0; i < 7; i++) g[i] = pc[i] != b[i];
    endtask : cmd
    task tallyAndFinish;
        $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tallyAndFinish
    task tLoads;
        wb(0, {IDX_CMD, 2'b00}, 0); `CHK(rd, 32'h0)
        wb(0, 12'h000, 0); `CHK(rd, 32'h0)
        cmd(16'hFFFF, 4); `CHK(g, 7'h40)
        cmd(16'hFFFE, 4); `CHK(g, 7'h20)
        cmd(16'hFFFD, 20); `CHK(g, 7'h58)
    endtask : tLoads
    task tSave;
        cmd(16'h0001, 2); `CHK(g, 7'h08)
        wb(0, {IDX_CMD, 2'b00}, 0); `CHK(rd, 32'h1)
        repeat (10) @(posedge clk); wb(0, {IDX_CMD, 2'b00}, 0); `CHK(rd, 32'h0)
        failMode <= 1; cmd(16'h0001, 14); wb(0, {IDX_CMD, 2'b00}, 0); `CHK(rd, 32'h2)
        failMode <= 0;
    endtask : tSave
    task tRefuse;
        driveStandstill <= 0; cmd(16'hFFFF, 4); `CHK(g, 7'h00)
        wb(0, {IDX_STATUS, 2'b00}, 0); `CHK(rd[3], 1'b1)
        driveStandstill <= 1; cmd(16'h0005, 4); `CHK(g, 7'h00)
    endtask : tRefuse
    task tMid;
        cmd(16'hFFFC, 8); `CHK(g, 7'h24)
        `CHK(midRunToPosRange, 1'b1)
        b = pc; ctrlWord <= 16'h0015; repeat (3) @(posedge clk); `CHK(pc[1] - b[1], 1)
        repeat (15) @(posedge clk); ctrlWord <= 16'h0014;
        cmd(16'hFFFB, 32); `CHK(g, 7'h4C)
        `CHK(midRunToPosRange, 1'b0)
        `CHK(motionAllow, 1'b0)
        targetPos <= 32'h0000_0100; repeat (3) @(posedge clk); `CHK(motionAllow, 1'b1)
    endtask : tMid
    task tRetry;
        wb(1, {IDX_RETRY, 2'b00}, 1); b = pc; safeRunFailed <= 1; @(posedge clk); safeRunFailed <= 0;
        repeat (8) @(posedge clk); `CHK(pc[0] - b[0], 0)
        repeat (8) @(posedge clk); `CHK(pc[0] - b[0], 1)
        wb(1, {IDX_RETRY, 2'b00}, 0); b = pc; safeRunFailed <= 1; @(posedge clk); safeRunFailed <= 0;
        repeat (20) @(posedge clk); `CHK(pc[0] - b[0], 0)
        safeTrigger <= 1; @(posedge clk); safeTrigger <= 0; repeat (2) @(posedge clk); `CHK(pc[0] - b[0], 1)
        cmd(16'hFFFA, 3); `CHK(deviceReset, 1'b1)
    endtask : tRetry
    // A second power-up with corrupt memory contents must report non-zero.
    task tBoot;
        rst_n <= 0; nvmValid <= 0; repeat (2) @(posedge clk); rst_n <= 1; repeat (3) @(posedge clk);
        `CHK(deviceReset, 1'b0)
        wb(0, {IDX_CMD, 2'b00}, 0); `CHK(rd, 32'h2)
    endtask : tBoot
    initial begin
        repeat (16) @(posedge clk); rst_n <= 1; repeat (3) @(posedge clk);
        tLoads(); tSave(); tRefuse(); tMid(); tRetry(); tBoot(); tallyAndFinish();
    end
    initial begin
        repeat (5000) @(posedge clk); badCount++; tallyAndFinish();
    end
endmodule : tb
